// [logic/dma_pkg.sv]
/*
  Shared constants and types of the two-channel cycle-stealing transfer controller.
  Assumes a 20-bit address space and a 16-bit internal data bus.
*/
`default_nettype none
package dma_pkg;
  // Address space and register decode.
  localparam int ADDR_W = 20;
  localparam logic [4:0] OFF_SRC = 5'h00;
  localparam logic [4:0] OFF_DST = 5'h04;
  localparam logic [4:0] OFF_RELOAD = 5'h08;
  localparam logic [4:0] OFF_CTRL = 5'h0c;
  localparam logic [4:0] OFF_COUNT = 5'h10;
  localparam int CH_BIT = 5;
  // Control register field positions.
  localparam int CTRL_W = 9;
  localparam int CTRL_SWREQ = 9;
  localparam int CTRL_PEND = 10;
  // Request source selection codes.
  localparam logic [3:0] SEL_SOFT = 4'h0;
  localparam logic [3:0] SEL_EXT = 4'h1;
  localparam logic [3:0] SEL_PERIPH_BASE = 4'h2;
  localparam logic [3:0] SEL_PERIPH_LAST = 4'he;
  localparam int NUM_PERIPH = 13;
  // The controller's own registers and the peripheral register area.
  localparam logic [19:0] REG_LO = 20'h00020;
  localparam logic [19:0] REG_HI = 20'h0003f;
  localparam logic [19:0] PERIPH_HI = 20'h003ff;
  // Clocks per bus cycle for memory and for the peripheral register area.
  localparam logic [1:0] WAIT_MEM = 2'h1;
  localparam logic [1:0] WAIT_PERIPH = 2'h2;
  // Reset values.
  localparam logic [19:0] ADDR_RESET = 20'h00000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RD = 4'b0010,
    S_WR = 4'b0100,
    S_SPARE = 4'b1000
  } state_t;

  typedef struct packed {
    logic [3:0] sel;
    logic dst_inc;
    logic src_inc;
    logic repeat_mode;
    logic byte_unit;
    logic enable;
  } ctrl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } bus_req_t;
endpackage : dma_pkg
`default_nettype wire

// [logic/two_channel_dma.sv]
/*
  Two-channel cycle-stealing transfer controller with an APB register slave.
  Assumes the internal bus answers reads in the same clock as the request and that
  the CPU yields the bus whenever cpu_hold is high.
*/
`default_nettype none
module two_channel_dma (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ext_irq_line,
  input wire logic [12:0] periph_irq,
  output dma_pkg::bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  output logic cpu_hold,
  output logic [1:0] dma_irq
);
  import dma_pkg::*;

  // Channel state.
  ctrl_t ctrl [2];
  ctrl_t next_ctrl [2];
  logic [19:0] src [2];
  logic [19:0] next_src [2];
  logic [19:0] dst [2];
  logic [19:0] next_dst [2];
  logic [19:0] ptr [2];
  logic [19:0] next_ptr [2];
  logic [15:0] reload [2];
  logic [15:0] next_reload [2];
  logic [15:0] cnt [2];
  logic [15:0] next_cnt [2];
  logic [1:0] fresh, next_fresh;
  logic [1:0] pend, next_pend;
  logic [1:0] ext_prev;
  logic [1:0] req_hit;
  // Engine state.
  state_t state, next_state;
  logic ch, next_ch;
  logic beat, next_beat;
  logic [1:0] wait_cnt, next_wait_cnt;
  logic [19:0] rd_a, next_rd_a;
  logic [19:0] wr_a, next_wr_a;
  logic [15:0] data, next_data;
  logic unit_byte, next_unit_byte;
  bus_req_t next_bus_req;
  logic next_cpu_hold;
  logic [1:0] next_dma_irq;
  // Register slave.
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic bad_addr, wr;
  logic wch;
  logic [4:0] woff;

  function automatic logic in_regs(input logic [19:0] a);
    in_regs = (a >= REG_LO) && (a <= REG_HI);
  endfunction : in_regs
  function automatic logic [1:0] beat_len(input logic [19:0] a);
    beat_len = (a <= PERIPH_HI) ? WAIT_PERIPH : WAIT_MEM;
  endfunction : beat_len

  // Address decode of the register slave.
  assign wch = paddr[CH_BIT];
  assign woff = paddr[4:0];
  assign bad_addr = (paddr[11:6] != 6'h00) || (paddr[1:0] != 2'h0) || (woff > OFF_COUNT);
  assign wr = psel & penable & pready & pwrite & ~bad_addr;

  // Per-channel request selection; peripheral lines are one-clock pulses.
  for (genvar c = 0; c < 2; c++) begin : g_req
    logic edge_hit;
    logic src_hit;
    logic sw_hit;
    assign edge_hit = ext_prev[c] & ~ext_irq_line[c];
    assign src_hit = (ctrl[c].sel == SEL_EXT) ? edge_hit :
                     ((ctrl[c].sel >= SEL_PERIPH_BASE) && (ctrl[c].sel <= SEL_PERIPH_LAST)) ?
                     periph_irq[ctrl[c].sel - SEL_PERIPH_BASE] : 1'b0;
    assign sw_hit = wr && (wch == 1'(c)) && (woff == OFF_CTRL) && pwdata[CTRL_SWREQ];
    assign req_hit[c] = ctrl[c].enable & (src_hit | sw_hit);
  end

  // Next values of the engine, the channels, the bus request and the register slave.
  always_comb begin
    logic c;
    logic [19:0] base;
    logic [19:0] cur_a;
    logic [19:0] beat_a;
    logic [19:0] nb_a;
    logic multi;
    logic last_wait;
    logic [15:0] rdv;
    c = 1'b0;
    base = ADDR_RESET;
    nb_a = ADDR_RESET;
    next_ctrl = ctrl;
    next_src = src;
    next_dst = dst;
    next_ptr = ptr;
    next_reload = reload;
    next_cnt = cnt;
    next_fresh = fresh;
    next_pend = pend;
    next_state = state;
    next_ch = ch;
    next_beat = beat;
    next_wait_cnt = wait_cnt;
    next_rd_a = rd_a;
    next_wr_a = wr_a;
    next_data = data;
    next_unit_byte = unit_byte;
    next_dma_irq = 2'b00;
    cur_a = (state == S_WR) ? wr_a : rd_a;
    beat_a = cur_a + {19'h00000, beat};
    multi = ~unit_byte & cur_a[0];
    last_wait = (wait_cnt == beat_len(beat_a) - 2'h1);
    rdv = in_regs(beat_a) ? 16'h0000 : bus_rdata;
    case (state)
      S_IDLE: begin
        if ((pend[0] & ctrl[0].enable) | (pend[1] & ctrl[1].enable)) begin
          c = (pend[0] & ctrl[0].enable) ? 1'b0 : 1'b1;
          next_ch = c;
          next_pend[c] = 1'b0;
          base = fresh[c] ? (ctrl[c].src_inc ? src[c] : dst[c]) : ptr[c];
          if (fresh[c]) begin
            next_ptr[c] = base;
            next_cnt[c] = reload[c];
            next_fresh[c] = 1'b0;
          end
          next_rd_a = ctrl[c].src_inc ? base : src[c];
          next_wr_a = ctrl[c].dst_inc ? base : dst[c];
          next_unit_byte = ctrl[c].byte_unit;
          next_beat = 1'b0;
          next_wait_cnt = 2'h0;
          next_state = S_RD;
        end
      end
      S_RD: begin
        if (!last_wait) begin
          next_wait_cnt = wait_cnt + 2'h1;
        end else begin
          next_wait_cnt = 2'h0;
          if (!multi) begin
            next_data = unit_byte ? {8'h00, rdv[7:0]} : rdv;
          end else if (!beat) begin
            next_data[7:0] = rdv[7:0];
          end else begin
            next_data[15:8] = rdv[7:0];
          end
          if (multi && !beat) begin
            next_beat = 1'b1;
          end else begin
            next_beat = 1'b0;
            next_state = S_WR;
          end
        end
      end
      S_WR: begin
        if (!last_wait) begin
          next_wait_cnt = wait_cnt + 2'h1;
        end else begin
          next_wait_cnt = 2'h0;
          if (multi && !beat) begin
            next_beat = 1'b1;
          end else begin
            next_beat = 1'b0;
            next_state = S_IDLE;
            if (ctrl[ch].src_inc | ctrl[ch].dst_inc) begin
              next_ptr[ch] = ptr[ch] + (unit_byte ? 20'h00001 : 20'h00002);
            end
            if (cnt[ch] == 16'h0000) begin
              next_dma_irq[ch] = 1'b1;
              if (ctrl[ch].repeat_mode) begin
                next_cnt[ch] = reload[ch];
              end else begin
                next_ctrl[ch].enable = 1'b0;
              end
            end else begin
              next_cnt[ch] = cnt[ch] - 16'h0001;
            end
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    // Software writes; registers set to increment are always writable.
    if (wr) begin
      case (woff)
        OFF_SRC: begin
          if (!ctrl[wch].enable || ctrl[wch].src_inc) begin
            next_src[wch] = pwdata[19:0];
          end
        end
        OFF_DST: begin
          if (!ctrl[wch].enable || ctrl[wch].dst_inc) begin
            next_dst[wch] = pwdata[19:0];
          end
        end
        OFF_RELOAD: begin
          next_reload[wch] = pwdata[15:0];
        end
        OFF_CTRL: begin
          if (!ctrl[wch].enable) begin
            next_ctrl[wch] = ctrl_t'(pwdata[CTRL_W-1:0]);
            next_ctrl[wch].dst_inc = pwdata[4] & ~pwdata[3];
          end
          next_ctrl[wch].enable = pwdata[0];
          if (pwdata[0] && !ctrl[wch].enable) begin
            next_fresh[wch] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // A new request wins over the service clear of the same cycle but not over a disable; requests merge into one flag.
    for (int i = 0; i < 2; i++) begin
      if (req_hit[i]) begin
        next_pend[i] = 1'b1;
      end
      if (!next_ctrl[i].enable) begin
        next_pend[i] = 1'b0;
      end
    end
    // Bus request for the coming clock; accesses to the own register range are dummies.
    nb_a = ((next_state == S_WR) ? next_wr_a : next_rd_a) + {19'h00000, next_beat};
    next_bus_req.valid = ((next_state == S_RD) || (next_state == S_WR)) && !in_regs(nb_a);
    next_bus_req.write = (next_state == S_WR);
    next_bus_req.word = ~next_unit_byte & ~nb_a[0] & ~((next_state == S_WR) ? next_wr_a[0] : next_rd_a[0]);
    next_bus_req.addr = nb_a;
    next_bus_req.wdata = (~next_unit_byte & next_wr_a[0]) ?
                         (next_beat ? {8'h00, next_data[15:8]} : {8'h00, next_data[7:0]}) : next_data;
    next_cpu_hold = (next_state != S_IDLE);
    // Register slave: one wait state, read data captured in the setup phase.
    next_pready = psel & penable & ~pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_pslverr = bad_addr;
      case (woff)
        OFF_SRC: next_prdata = {12'h000, (ctrl[wch].enable && ctrl[wch].src_inc && !fresh[wch]) ?
                                ptr[wch] : src[wch]};
        OFF_DST: next_prdata = {12'h000, (ctrl[wch].enable && ctrl[wch].dst_inc && !fresh[wch]) ?
                                ptr[wch] : dst[wch]};
        OFF_RELOAD: next_prdata = {16'h0000, reload[wch]};
        OFF_CTRL: next_prdata = {21'h000000, pend[wch], 1'b0, ctrl[wch]};
        OFF_COUNT: next_prdata = {16'h0000, cnt[wch]};
        default: next_prdata = 32'h00000000;
      endcase
      if (bad_addr) begin
        next_prdata = 32'h00000000;
      end
    end
  end

  // Registers of the whole block, including the dma_irq pulses and the sampled ext_irq_line levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i] <= '0;
        src[i] <= ADDR_RESET;
        dst[i] <= ADDR_RESET;
        ptr[i] <= ADDR_RESET;
        reload[i] <= COUNT_RESET;
        cnt[i] <= COUNT_RESET;
      end
      fresh <= 2'b00;
      pend <= 2'b00;
      ext_prev <= 2'b11;
      state <= S_IDLE;
      ch <= 1'b0;
      beat <= 1'b0;
      wait_cnt <= 2'h0;
      rd_a <= ADDR_RESET;
      wr_a <= ADDR_RESET;
      data <= 16'h0000;
      unit_byte <= 1'b0;
      bus_req <= '0;
      cpu_hold <= 1'b0;
      dma_irq <= 2'b00;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      src <= next_src;
      dst <= next_dst;
      ptr <= next_ptr;
      reload <= next_reload;
      cnt <= next_cnt;
      fresh <= next_fresh;
      pend <= next_pend;
      ext_prev <= ext_irq_line;
      state <= next_state;
      ch <= next_ch;
      beat <= next_beat;
      wait_cnt <= next_wait_cnt;
      rd_a <= next_rd_a;
      wr_a <= next_wr_a;
      data <= next_data;
      unit_byte <= next_unit_byte;
      bus_req <= next_bus_req;
      cpu_hold <= next_cpu_hold;
      dma_irq <= next_dma_irq;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Checks of the engine and the channels.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold;
    bus_req.valid |-> cpu_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("bus used without holding the cpu");
  property p_regs;
    bus_req.valid |-> !((bus_req.addr >= REG_LO) && (bus_req.addr <= REG_HI));
  endproperty
  a_regs: assert property (p_regs) else $error("own register range accessed");
  property p_prio;
    (state == S_IDLE) && (pend == 2'b11) && ctrl[0].enable && ctrl[1].enable |=> (state == S_RD) && !ch;
  endproperty
  a_prio: assert property (p_prio) else $error("channel one served before channel zero");
  property p_inactive;
    (state == S_IDLE) && !ctrl[0].enable && !ctrl[1].enable |=> (state == S_IDLE);
  endproperty
  a_inactive: assert property (p_inactive) else $error("transfer started while disabled");
  property p_odd;
    (state == S_RD) && beat |-> !unit_byte && rd_a[0];
  endproperty
  a_odd: assert property (p_odd) else $error("extra read cycle without odd word");
  property p_periph;
    bus_req.valid && (bus_req.addr <= PERIPH_HI) && (wait_cnt == 2'h0) |=> bus_req.valid && $stable(bus_req.addr);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral cycle shorter than two clocks");
  property p_byte;
    bus_req.valid && unit_byte |-> !bus_req.word;
  endproperty
  a_byte: assert property (p_byte) else $error("word access in byte mode");
  for (genvar c = 0; c < 2; c++) begin : g_chk
    property p_bothinc;
      !(ctrl[c].src_inc && ctrl[c].dst_inc);
    endproperty
    a_bothinc: assert property (p_bothinc) else $error("both addresses incrementing");
    property p_irq;
      dma_irq[c] |-> ($past(state) == S_WR) && ($past(ch) == 1'(c)) && ($past(cnt[c]) == 16'h0000);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without counter underflow");
    property p_single;
      dma_irq[c] && !ctrl[c].repeat_mode && !$past(wr) |-> !ctrl[c].enable;
    endproperty
    a_single: assert property (p_single) else $error("single mode stayed enabled");
    property p_repeat;
      dma_irq[c] && ctrl[c].repeat_mode && !$past(wr) |-> ctrl[c].enable && (cnt[c] == reload[c]);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat mode did not reload");
  end
  c_odd_write: cover property ((state == S_WR) && beat);
  c_irq: cover property (dma_irq != 2'b00);
  c_both_pending: cover property (pend == 2'b11);
  c_periph: cover property (bus_req.valid && (bus_req.addr <= PERIPH_HI));
endmodule : two_channel_dma
`default_nettype wire

// [verification/bus_memory_model.sv]
/*
  Behavioural model of internal memory and the peripheral register area on the transfer bus.
  Assumes reads are answered in the same clock as the request and writes land at the edge.
*/
`default_nettype none
module bus_memory_model (
  input wire logic pclk,
  input wire dma_pkg::bus_req_t bus_req,
  output logic [15:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dma_pkg::*;
  logic [7:0] mem [0:8191];
  logic [12:0] a;
  logic flip = 1'b0;
  // Each byte starts as a pattern of its own address, so misplaced reads show up.
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  assign a = bus_req.addr[12:0];
  // Reads answer at once; a bus that is not reading shows a pattern that changes every cycle.
  assign bus_rdata = (bus_req.valid && !bus_req.write) ? {mem[a + 13'h1], mem[a]} : (flip ? 16'ha5c3 : 16'h5a3c);
  // Writes land at the clock edge; an odd word arrives as two byte beats.
  always @(posedge pclk) begin
    flip <= ~flip;
    if (bus_req.valid && bus_req.write) begin
      mem[a] <= bus_req.wdata[7:0];
      if (bus_req.word) begin
        mem[a + 13'h1] <= bus_req.wdata[15:8];
      end
    end
  end
endmodule : bus_memory_model
`default_nettype wire

// [verification/two_channel_dma_test.sv]
/*
  Self-checking bench of the two-channel transfer controller.
  Assumes the bus memory model beside it and the design package.
*/
`default_nettype none
module two_channel_dma_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ext_irq_line = 2'h3;
  logic [12:0] periph_irq = 13'h0000;
  bus_req_t bus_req;
  logic [15:0] bus_rdata;
  logic cpu_hold;
  logic [1:0] dma_irq;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  two_channel_dma u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_line(ext_irq_line), .periph_irq(periph_irq), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cpu_hold(cpu_hold), .dma_irq(dma_irq));
  bus_memory_model u_mem (.pclk(pclk), .bus_req(bus_req), .bus_rdata(bus_rdata));

  // Clock of 40 ns period.
  always #20 pclk = ~pclk;

  // Cuts a hang short well past the expected run length.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [31:0] ctl(input logic en, bt, rp, si, di, input logic [3:0] sel);
    return {23'h0, sel, di, si, rp, bt, en};
  endfunction : ctl

  function automatic logic [31:0] pat(input logic [19:0] a);
    return {24'h0, a[7:0] ^ 8'h5a};
  endfunction : pat

  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task rdc(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q & m, exp);
  endtask : rdc

  // Disables the channel, then loads addresses, reload value and control.
  task cfg(input logic ch, input logic [19:0] s, d, input logic [15:0] rl, input logic [31:0] c);
    logic [11:0] b;
    b = {6'h00, ch, 5'h00};
    wr(b + 12'(OFF_CTRL), 32'h0);
    wr(b + 12'(OFF_SRC), {12'h000, s});
    wr(b + 12'(OFF_DST), {12'h000, d});
    wr(b + 12'(OFF_RELOAD), {16'h0000, rl});
    wr(b + 12'(OFF_CTRL), c);
  endtask : cfg

  task swr(input logic ch, input logic [31:0] c);
    wr({6'h00, ch, 5'h00} + 12'(OFF_CTRL), c | (32'h1 << CTRL_SWREQ));
  endtask : swr

  task pulse(input logic [12:0] m);
    @(posedge pclk);
    periph_irq <= m;
    @(posedge pclk);
    periph_irq <= 13'h0000;
  endtask : pulse

  // Waits for one transfer and judges its length, first address and interrupt pulses.
  task run(input string what, input int ecyc, input logic [19:0] ea, input logic [1:0] eirq, input int tail);
    int cyc;
    logic [19:0] a0;
    logic [1:0] irq;
    cyc = 0;
    a0 = 20'h0;
    irq = 2'h0;
    repeat (20) begin
      @(posedge pclk);
      irq |= dma_irq;
      if (cpu_hold === 1'b1) break;
    end
    if (cpu_hold === 1'b1) a0 = bus_req.addr;
    while (cpu_hold === 1'b1 && cyc < 20) begin
      cyc++;
      @(posedge pclk);
      irq |= dma_irq;
    end
    repeat (tail) begin
      @(posedge pclk);
      irq |= dma_irq;
    end
    check({what, " beats"}, 32'(cyc), 32'(ecyc));
    if (ecyc > 0 && ea !== 20'hfffff) check({what, " addr"}, {12'h0, a0}, {12'h0, ea});
    check({what, " irq"}, {30'h0, irq}, {30'h0, eirq});
  endtask : run

  task t_regs;
    logic [31:0] q;
    logic e;
    rdc("src reset", 12'h000, 32'hffffffff, {12'h0, ADDR_RESET});
    rdc("count reset", 12'h030, 32'hffffffff, {16'h0, COUNT_RESET});
    apb(1'b0, 12'h014, 32'h0, q, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    check("mapped err", {31'h0, e}, 32'h0);
  endtask : t_regs

  task t_single;
    logic [31:0] c;
    c = ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, SEL_SOFT);
    cfg(1'b0, 20'h01000, 20'h01800, 16'h0001, c);
    swr(1'b0, c);
    run("single 1", 2, 20'h01000, 2'b00, 3);
    swr(1'b0, c);
    run("single 2", 2, 20'h01001, 2'b01, 3);
    check("single data", {24'h0, u_mem.mem[13'h1800]}, pat(20'h01001));
    rdc("single off", 12'h00c, 32'h1, 32'h0);
    swr(1'b0, c & 32'hfffffffe);
    run("single idle", 0, 20'h0, 2'b00, 3);
  endtask : t_single

  task t_repeat;
    logic [31:0] c;
    c = ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, SEL_SOFT);
    cfg(1'b0, 20'h01003, 20'h01a00, 16'h0000, c);
    swr(1'b0, c);
    run("repeat 1", 3, 20'h01003, 2'b01, 3);
    check("odd word lo", {24'h0, u_mem.mem[13'h1a00]}, pat(20'h01003));
    check("odd word hi", {24'h0, u_mem.mem[13'h1a01]}, pat(20'h01004));
    rdc("live ptr", 12'h004, 32'hfffff, 32'h01a02);
    rdc("repeat on", 12'h00c, 32'h1, 32'h1);
    wr(12'h000, 32'h01111);
    rdc("fixed locked", 12'h000, 32'hfffff, 32'h01003);
    swr(1'b0, c);
    run("repeat 2", 3, 20'h01003, 2'b01, 3);
    check("dst step", {24'h0, u_mem.mem[13'h1a02]}, pat(20'h01003));
    wr(12'h00c, 32'h0);
  endtask : t_repeat

  task t_prio;
    cfg(1'b0, 20'h01100, 20'h01900, 16'h00ff, ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h5));
    cfg(1'b1, 20'h01200, 20'h01901, 16'h00ff, ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'he));
    pulse(13'h1008);
    run("first ch", 2, 20'h01100, 2'b00, 0);
    run("second ch", 2, 20'h01200, 2'b00, 3);
    wr(12'h00c, 32'h0);
  endtask : t_prio

  task t_sources;
    for (int k = 0; k < NUM_PERIPH; k++) begin
      wr(12'h02c, 32'h0);
      wr(12'h02c, ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'(k + 2)));
      pulse(13'(1 << ((k + 1) % NUM_PERIPH)));
      run("other line", 0, 20'h0, 2'b00, 0);
      pulse(13'(1 << k));
      run("own line", 2, 20'h01200, 2'b00, 0);
    end
    for (int ch = 0; ch < 2; ch++) begin
      cfg(ch[0], 20'h01300, 20'h01902, 16'h0005, ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, SEL_EXT));
      @(posedge pclk);
      ext_irq_line[ch] <= 1'b0;
      run("ext fall", 2, 20'h01300, 2'b00, 0);
      @(posedge pclk);
      ext_irq_line <= 2'h3;
      run("ext rise", 0, 20'h0, 2'b00, 0);
      wr({6'h00, ch[0], 5'h00} + 12'(OFF_CTRL), 32'h0);
    end
  endtask : t_sources

  task t_area;
    logic [31:0] c;
    c = ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, SEL_SOFT);
    cfg(1'b0, 20'h00020, 20'h01a10, 16'h0000, c);
    swr(1'b0, c);
    run("own regs", 3, 20'hfffff, 2'b01, 3);
    check("own regs data", {24'h0, u_mem.mem[13'h1a10]}, 32'h0);
    cfg(1'b0, 20'h00100, 20'h01a10, 16'h0000, c);
    swr(1'b0, c);
    run("periph src", 3, 20'h00100, 2'b01, 3);
    check("periph data", {24'h0, u_mem.mem[13'h1a10]}, pat(20'h00100));
    // An even source word written to an odd destination goes out as two byte beats.
    c = ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, SEL_SOFT);
    cfg(1'b1, 20'h01400, 20'h01a21, 16'h0000, c);
    swr(1'b1, c);
    run("odd dst", 3, 20'h01400, 2'b10, 3);
    check("odd dst lo", {24'h0, u_mem.mem[13'h1a21]}, pat(20'h01400));
    check("odd dst hi", {24'h0, u_mem.mem[13'h1a22]}, pat(20'h01401));
  endtask : t_area

  // Reset, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_single();
    t_repeat();
    t_prio();
    t_sources();
    t_area();
    give_verdict();
  end
endmodule : two_channel_dma_test
`default_nettype wire
